// [src/dss_sequencer.sv]
/*
 * Step sequencer for one dimmer channel: start conditions, master
 * on/off, suspend, manual interruption, resume, loops and step actions.
 * Assumes decoded telegrams arrive as one-cycle strobes on i_clk and
 * configuration is held stable while the sequence runs.
 */
//
// Overview of operation
// - Only steps below the configured count run
// - Any enabled start condition activates a step
// - Suspend one pauses, zero continues
// - Manual commands interrupt an active sequence
// - Resume by suspend, off-time, or next step
// - Suspend or off-time resume executes resume step unconditionally
// - Master off blocks activations; polarity configurable
// - Master on: nothing, or force a step
// - Master on clears manual interruption
// - Master off: finish, force step, or stop
// - Time starts idle until time received
// - Time of day advances from internal timer
// - Wait start fires after interval, not step one
// - Trigger one activates step, continues from it
// - Trigger zero activates step and resets sequence
// - Shared scene byte activates lowest matching step
// - Action none changes no output
// - Loop jumps back, unlimited or counted
// - Send-scene action drives one shared output
// - Brightness fades, time scaled to full range
//
`timescale 1ns/1ps
`default_nettype none
module dss_sequencer #(
	parameter int CS_CYCLES = dss_pkg::CS_CYCLES
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Configuration
	input wire dss_pkg::dss_gcfg_t i_gcfg,
	input wire dss_pkg::dss_step_cfg_t [dss_pkg::NSTEP-1:0] i_step_cfg,
	// Telegrams
	input wire dss_pkg::dss_bit_tg_t i_suspend,
	input wire dss_pkg::dss_bit_tg_t i_master,
	input wire logic [dss_pkg::NSTEP-1:0] i_trig_stb,
	input wire logic [dss_pkg::NSTEP-1:0] i_trig_val,
	input wire dss_pkg::dss_byte_tg_t i_scene,
	input wire dss_pkg::dss_time_tg_t i_time,
	input wire logic i_manual,
	// Dimmer output
	output logic [dss_pkg::LVL_W-1:0] o_level,
	output logic o_fading,
	// Scene output
	output logic o_scene_stb,
	output logic [7:0] o_scene_num,
	// Status
	output logic [dss_pkg::IDX_W-1:0] o_cur_step,
	output logic o_seq_active,
	output logic o_enabled,
	output logic o_suspended,
	output logic o_interrupted,
	output logic o_time_valid
);
	// ==========================================================
	// State
	typedef struct packed {
		logic [dss_pkg::CSC_W-1:0] div;
		logic cs_tick;
		logic enabled;
		logic suspended;
		logic interrupted;
		logic active;
		logic [dss_pkg::IDX_W-1:0] cur;
		logic [dss_pkg::SOD_W-1:0] wait_s;
		logic [dss_pkg::SOD_W-1:0] off_s;
		logic loop_armed;
		logic [dss_pkg::IDX_W-1:0] loop_idx;
		logic [7:0] loop_left;
		logic pend;
		logic [dss_pkg::IDX_W-1:0] pend_step;
		logic scene_stb;
		logic [7:0] scene_num;
	} dss_seq_st_t;

	dss_seq_st_t s_reg;
	dss_seq_st_t s_next;

	logic [dss_pkg::SOD_W-1:0] sod;
	logic tod_valid;
	logic sec_tick;
	logic fd_start;
	logic fd_abort;
	logic [dss_pkg::LVL_W-1:0] fd_target;
	logic [dss_pkg::SOD_W-1:0] fd_fade;

	// ==========================================================
	// Helpers
	function automatic logic in_range(input logic [dss_pkg::IDX_W-1:0] idx,
		input logic [dss_pkg::CNT_W-1:0] num);
		in_range = ({1'b0, idx} < num);
	endfunction

	// Lowest set bit wins when several steps fire in one cycle
	function automatic logic [dss_pkg::IDX_W:0] first_set(input logic [dss_pkg::NSTEP-1:0] v);
		first_set = '0;
		for (int k = dss_pkg::NSTEP - 1; k >= 0; k--) begin
			if (v[k]) begin
				first_set = {1'b1, 5'(k)};
			end
		end
	endfunction

	// ==========================================================
	// Time base and time of day
	dss_tod u_tod (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_cs_tick(s_reg.cs_tick),
		.i_time(i_time),
		.o_sod(sod),
		.o_valid(tod_valid),
		.o_sec_tick(sec_tick)
	);

	dss_fader u_fader (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_cs_tick(s_reg.cs_tick),
		.i_start(fd_start),
		.i_target(fd_target),
		.i_fade_s(fd_fade),
		.i_abort(fd_abort),
		.o_level(o_level),
		.o_busy(o_fading)
	);

	// ==========================================================
	// Start condition vectors
	logic [dss_pkg::NSTEP-1:0] trig_hit;
	logic [dss_pkg::NSTEP-1:0] scene_hit;
	logic [dss_pkg::NSTEP-1:0] tod_hit;

	always_comb begin
		trig_hit = '0;
		scene_hit = '0;
		tod_hit = '0;
		for (int k = 0; k < dss_pkg::NSTEP; k++) begin
			trig_hit[k] = i_trig_stb[k] && i_step_cfg[k].tele_en &&
				in_range(5'(k), i_gcfg.num_steps);
			scene_hit[k] = i_scene.stb && i_step_cfg[k].scene_en &&
				(i_scene.val == i_step_cfg[k].scene) &&
				in_range(5'(k), i_gcfg.num_steps);
			tod_hit[k] = sec_tick && tod_valid && (i_step_cfg[k].time_mode == dss_pkg::DSS_TM_TOD) &&
				(i_step_cfg[k].start_time == sod) &&
				in_range(5'(k), i_gcfg.num_steps);
		end
	end

	// ==========================================================
	// Sequencing
	logic [dss_pkg::IDX_W:0] trig_sel;
	logic [dss_pkg::IDX_W:0] scene_sel;
	logic [dss_pkg::IDX_W:0] tod_sel;
	logic [dss_pkg::IDX_W-1:0] nxt;
	logic wait_hit;
	logic master_on;
	logic req;
	logic req_force;
	logic req_reset;
	logic [dss_pkg::IDX_W-1:0] req_step;
	logic gate_ok;
	dss_pkg::dss_step_cfg_t sc;

	assign trig_sel = first_set(trig_hit);
	assign scene_sel = first_set(scene_hit);
	assign tod_sel = first_set(tod_hit);
	assign nxt = s_reg.cur + 5'h01;
	// Step one never has a predecessor, so it cannot wait
	assign wait_hit = sec_tick && s_reg.active && (nxt != '0) && in_range(nxt, i_gcfg.num_steps) &&
		(i_step_cfg[nxt].time_mode == dss_pkg::DSS_TM_WAIT) &&
		(s_reg.wait_s + 17'h00001 >= i_step_cfg[nxt].start_time);
	assign master_on = (i_master.val == i_gcfg.on_value);

	always_comb begin
		s_next = s_reg;
		s_next.scene_stb = 1'b0;
		fd_start = 1'b0;
		fd_abort = 1'b0;
		fd_target = '0;
		fd_fade = '0;
		req = 1'b0;
		req_force = 1'b0;
		req_reset = 1'b0;
		req_step = '0;
		sc = '0;

		// Centisecond divider
		s_next.cs_tick = 1'b0;
		s_next.div = s_reg.div + 20'h00001;
		if (s_next.div == 20'(CS_CYCLES)) begin
			s_next.div = '0;
			s_next.cs_tick = 1'b1;
		end

		if (sec_tick) begin
			if (s_reg.wait_s != '1) begin
				s_next.wait_s = s_reg.wait_s + 17'h00001;
			end
			if (s_reg.interrupted && s_reg.off_s != '1) begin
				s_next.off_s = s_reg.off_s + 17'h00001;
			end
		end

		// Manual operation
		if (i_manual && s_reg.enabled && s_reg.active) begin
			s_next.interrupted = 1'b1;
			s_next.off_s = '0;
			s_next.pend = 1'b0;
		end

		// Suspend telegram
		if (i_suspend.stb) begin
			s_next.suspended = i_suspend.val;
			if (!i_suspend.val && s_reg.interrupted && s_reg.enabled && !i_manual) begin
				s_next.interrupted = 1'b0;
				req = 1'b1;
				req_force = 1'b1;
				req_step = i_gcfg.resume_step;
			end
		end

		// Off-time expiry
		if (!req && s_reg.interrupted && s_reg.enabled && !i_manual &&
			i_gcfg.resume_mode == dss_pkg::DSS_RES_OFFT &&
			s_reg.off_s >= i_gcfg.off_time_s) begin
			s_next.interrupted = 1'b0;
			req = 1'b1;
			req_force = 1'b1;
			req_step = i_gcfg.resume_step;
		end

		// Pending loop jump
		if (!req && s_reg.pend && s_reg.enabled && !s_reg.suspended && !s_reg.interrupted) begin
			s_next.pend = 1'b0;
			req = 1'b1;
			req_force = 1'b1;
			req_step = s_reg.pend_step;
		end

		// Ordinary start conditions
		gate_ok = s_reg.enabled && !s_reg.suspended &&
			(!s_reg.interrupted || i_gcfg.resume_mode == dss_pkg::DSS_RES_NEXT);
		if (!req && gate_ok) begin
			if (trig_sel[dss_pkg::IDX_W]) begin
				req = 1'b1;
				req_step = trig_sel[dss_pkg::IDX_W-1:0];
				req_reset = !i_trig_val[trig_sel[dss_pkg::IDX_W-1:0]];
			end else if (scene_sel[dss_pkg::IDX_W]) begin
				req = 1'b1;
				req_step = scene_sel[dss_pkg::IDX_W-1:0];
			end else if (tod_sel[dss_pkg::IDX_W]) begin
				req = 1'b1;
				req_step = tod_sel[dss_pkg::IDX_W-1:0];
			end else if (wait_hit && !s_reg.interrupted) begin
				req = 1'b1;
				req_step = nxt;
			end
			if (req && s_reg.interrupted && !i_manual) begin
				s_next.interrupted = 1'b0;
			end
		end

		// Master on/off overrides any step request made earlier in its cycle
		if (i_master.stb) begin
			if (master_on) begin
				s_next.enabled = 1'b1;
				s_next.interrupted = 1'b0;
				req = i_gcfg.on_exec;
				req_force = 1'b1;
				req_reset = 1'b0;
				req_step = i_gcfg.on_step;
			end else begin
				s_next.enabled = 1'b0;
				s_next.pend = 1'b0;
				req = 1'b0;
				case (i_gcfg.off_mode)
					dss_pkg::DSS_OFF_STEP: begin
						req = 1'b1;
						req_force = 1'b1;
						req_reset = 1'b0;
						req_step = i_gcfg.off_step;
					end
					dss_pkg::DSS_OFF_STOP: begin
						fd_abort = 1'b1;
					end
					default: begin
						// Running fade is left to finish
					end
				endcase
			end
		end

		// Execute the selected step
		if (req && in_range(req_step, i_gcfg.num_steps)) begin
			sc = i_step_cfg[req_step];
			s_next.active = 1'b1;
			s_next.cur = req_step;
			s_next.wait_s = '0;
			if (req_reset) begin
				s_next.loop_armed = 1'b0;
				s_next.pend = 1'b0;
			end
			case (sc.action)
				dss_pkg::DSS_ACT_BRIGHT: begin
					fd_start = 1'b1;
					fd_target = sc.level;
					fd_fade = sc.fade_s;
				end
				dss_pkg::DSS_ACT_SCENE: begin
					s_next.scene_stb = 1'b1;
					s_next.scene_num = sc.scene;
				end
				dss_pkg::DSS_ACT_LOOP: begin
					if (!sc.loop_limited) begin
						s_next.pend = 1'b1;
						s_next.pend_step = sc.loop_to;
					end else if (!(s_reg.loop_armed && !req_reset && s_reg.loop_idx == req_step)) begin
						if (sc.loop_num != 8'h00) begin
							s_next.loop_armed = 1'b1;
							s_next.loop_idx = req_step;
							s_next.loop_left = sc.loop_num - 8'h01;
							s_next.pend = 1'b1;
							s_next.pend_step = sc.loop_to;
						end
					end else if (s_reg.loop_left != 8'h00) begin
						s_next.loop_left = s_reg.loop_left - 8'h01;
						s_next.pend = 1'b1;
						s_next.pend_step = sc.loop_to;
					end else begin
						s_next.loop_armed = 1'b0;
					end
				end
				default: begin
					// No output change, step only marks time
				end
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s_reg <= '{enabled: 1'b1, scene_num: dss_pkg::SCENE_RST, default: '0};
		end else begin
			s_reg <= s_next;
		end
	end

	// ==========================================================
	// Outputs
	assign o_scene_stb = s_reg.scene_stb;
	assign o_scene_num = s_reg.scene_num;
	assign o_cur_step = s_reg.cur;
	assign o_seq_active = s_reg.active;
	assign o_enabled = s_reg.enabled;
	assign o_suspended = s_reg.suspended;
	assign o_interrupted = s_reg.interrupted;
	assign o_time_valid = tod_valid;
endmodule
`default_nettype wire

// [inc/dss_pkg.sv]
/*
 * Shared types and constants of the dimmer step sequencer.
 * Assumes a 100 MHz system clock and telegrams already decoded into strobes.
 */
package dss_pkg;
	// ==========================================================
	// Sizes and timing
	localparam int NSTEP = 32;
	localparam int IDX_W = 5;
	localparam int CNT_W = 6;
	localparam int SOD_W = 17;
	localparam int LVL_W = 7;
	localparam logic [SOD_W-1:0] SOD_DAY = 17'h15180;
	localparam int CLK_NS = 10;
	localparam int CS_NS = 10_000_000;
	localparam int CS_CYCLES = CS_NS / CLK_NS;
	localparam int CSC_W = 20;
	localparam logic [6:0] CS_PER_S = 7'h64;
	localparam logic [LVL_W-1:0] LVL_MAX = 7'h64;
	localparam logic [4:0] HOUR_LIM = 5'h18;
	localparam logic [5:0] MIN_LIM = 6'h3C;
	localparam logic [SOD_W-1:0] S_PER_H = 17'h00E10;
	localparam logic [SOD_W-1:0] S_PER_M = 17'h0003C;
	// Reset values
	localparam logic [LVL_W-1:0] LVL_RST = 7'h00;
	localparam logic [7:0] SCENE_RST = 8'h00;

	// ==========================================================
	// Modes
	typedef enum logic [1:0] {DSS_TM_OFF, DSS_TM_TOD, DSS_TM_WAIT} dss_tmode_t;
	typedef enum logic [1:0] {DSS_ACT_NONE, DSS_ACT_LOOP, DSS_ACT_SCENE, DSS_ACT_BRIGHT} dss_action_t;
	typedef enum logic [1:0] {DSS_RES_OBJ, DSS_RES_OFFT, DSS_RES_NEXT} dss_resume_t;
	typedef enum logic [1:0] {DSS_OFF_FINISH, DSS_OFF_STEP, DSS_OFF_STOP} dss_offmode_t;

	// ==========================================================
	// Configuration carriers
	typedef struct packed {
		dss_tmode_t time_mode;
		logic [SOD_W-1:0] start_time;
		logic tele_en;
		logic scene_en;
		logic [7:0] scene;
		dss_action_t action;
		logic [LVL_W-1:0] level;
		logic [SOD_W-1:0] fade_s;
		logic [IDX_W-1:0] loop_to;
		logic loop_limited;
		logic [7:0] loop_num;
	} dss_step_cfg_t;

	typedef struct packed {
		logic [CNT_W-1:0] num_steps;
		dss_resume_t resume_mode;
		logic [SOD_W-1:0] off_time_s;
		logic [IDX_W-1:0] resume_step;
		logic on_value;
		logic on_exec;
		logic [IDX_W-1:0] on_step;
		dss_offmode_t off_mode;
		logic [IDX_W-1:0] off_step;
	} dss_gcfg_t;

	// Telegram carriers: one-cycle strobe with value
	typedef struct packed {
		logic stb;
		logic val;
	} dss_bit_tg_t;

	typedef struct packed {
		logic stb;
		logic [7:0] val;
	} dss_byte_tg_t;

	typedef struct packed {
		logic stb;
		logic [23:0] val;
	} dss_time_tg_t;
endpackage

// [src/dss_tod.sv]
/*
 * Time-of-day keeper in seconds of day.
 * Assumes a one-cycle centisecond tick from the same clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
module dss_tod (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Time base and setting
	input wire logic i_cs_tick,
	input wire dss_pkg::dss_time_tg_t i_time,
	// Time state
	output logic [dss_pkg::SOD_W-1:0] o_sod,
	output logic o_valid,
	output logic o_sec_tick
);
	typedef struct packed {
		logic [6:0] cs;
		logic [dss_pkg::SOD_W-1:0] sod;
		logic valid;
		logic sec;
	} dss_tod_st_t;

	dss_tod_st_t s_reg;
	dss_tod_st_t s_next;
	logic [4:0] hh;
	logic [5:0] mm;
	logic [5:0] ss;

	assign hh = i_time.val[20:16];
	assign mm = i_time.val[13:8];
	assign ss = i_time.val[5:0];

	always_comb begin
		s_next = s_reg;
		s_next.sec = 1'b0;
		if (i_cs_tick) begin
			s_next.cs = s_reg.cs + 7'h01;
			if (s_next.cs == dss_pkg::CS_PER_S) begin
				s_next.cs = 7'h00;
				s_next.sec = 1'b1;
				s_next.sod = s_reg.sod + 17'h00001;
				if (s_next.sod == dss_pkg::SOD_DAY) begin
					s_next.sod = '0;
				end
			end
		end
		// Out-of-range telegrams are dropped, keeping the running time
		if (i_time.stb && hh < dss_pkg::HOUR_LIM && mm < dss_pkg::MIN_LIM && ss < dss_pkg::MIN_LIM) begin
			s_next.sod = 17'(hh * dss_pkg::S_PER_H) + 17'(mm * dss_pkg::S_PER_M) + 17'(ss);
			s_next.cs = 7'h00;
			s_next.valid = 1'b1;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign o_sod = s_reg.sod;
	assign o_valid = s_reg.valid;
	assign o_sec_tick = s_reg.sec;
endmodule
`default_nettype wire

// [src/dss_fader.sv]
/*
 * Linear fader: one percent per fade_s centiseconds, so fade_s is the
 * full-range time in seconds. Assumes a one-cycle centisecond tick.
 */
`timescale 1ns/1ps
`default_nettype none
module dss_fader (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Control
	input wire logic i_cs_tick,
	input wire logic i_start,
	input wire logic [dss_pkg::LVL_W-1:0] i_target,
	input wire logic [dss_pkg::SOD_W-1:0] i_fade_s,
	input wire logic i_abort,
	// Output
	output logic [dss_pkg::LVL_W-1:0] o_level,
	output logic o_busy
);
	typedef struct packed {
		logic [dss_pkg::LVL_W-1:0] level;
		logic [dss_pkg::LVL_W-1:0] target;
		logic [dss_pkg::SOD_W-1:0] per;
		logic [dss_pkg::SOD_W-1:0] cnt;
		logic busy;
	} dss_fade_st_t;

	dss_fade_st_t s_reg;
	dss_fade_st_t s_next;
	logic [dss_pkg::LVL_W-1:0] tgt;

	// Targets above full scale clamp to full scale
	assign tgt = (i_target > dss_pkg::LVL_MAX) ? dss_pkg::LVL_MAX : i_target;

	always_comb begin
		s_next = s_reg;
		if (s_reg.busy && i_cs_tick) begin
			s_next.cnt = s_reg.cnt + 17'h00001;
			if (s_next.cnt >= s_reg.per) begin
				s_next.cnt = '0;
				s_next.level = (s_reg.level < s_reg.target) ? s_reg.level + 7'h01 :
					s_reg.level - 7'h01;
				s_next.busy = (s_next.level != s_reg.target);
			end
		end
		if (i_abort) begin
			s_next.busy = 1'b0;
		end
		if (i_start) begin
			s_next.target = tgt;
			s_next.per = i_fade_s;
			s_next.cnt = '0;
			if (i_fade_s == '0) begin
				s_next.level = tgt;
				s_next.busy = 1'b0;
			end else begin
				s_next.busy = (s_reg.level != tgt);
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s_reg <= '{level: dss_pkg::LVL_RST, target: dss_pkg::LVL_RST, default: '0};
		end else begin
			s_reg <= s_next;
		end
	end

	assign o_level = s_reg.level;
	assign o_busy = s_reg.busy;
endmodule
`default_nettype wire

// [tb/dss_sequencer_properties.sv]
/*
 * Port-level checks of the dimmer step sequencer.
 * Assumes it is bound into dss_sequencer; one clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
module dss_sequencer_properties (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Watched inputs
	input wire dss_pkg::dss_gcfg_t i_gcfg,
	input wire dss_pkg::dss_bit_tg_t i_suspend,
	input wire dss_pkg::dss_bit_tg_t i_master,
	input wire dss_pkg::dss_time_tg_t i_time,
	input wire logic i_manual,
	// Watched outputs
	input wire logic [dss_pkg::LVL_W-1:0] o_level,
	input wire logic o_scene_stb,
	input wire logic [dss_pkg::IDX_W-1:0] o_cur_step,
	input wire logic o_seq_active,
	input wire logic o_enabled,
	input wire logic o_suspended,
	input wire logic o_interrupted,
	input wire logic o_time_valid
);
	// ==========
	// Helpers
	logic m_on;
	logic m_off;
	assign m_on = i_master.stb && (i_master.val == i_gcfg.on_value);
	assign m_off = i_master.stb && (i_master.val != i_gcfg.on_value);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	// ==========
	// Properties
	property p_level_max;
		o_level <= dss_pkg::LVL_MAX;
	endproperty
	a_level_max: assert property (p_level_max)
		else $error("level above full scale");
	property p_susp_set;
		i_suspend.stb && i_suspend.val && !i_master.stb |=> o_suspended;
	endproperty
	a_susp_set: assert property (p_susp_set)
		else $error("suspend one did not pause");
	property p_susp_clr;
		i_suspend.stb && !i_suspend.val && !i_master.stb |=> !o_suspended;
	endproperty
	a_susp_clr: assert property (p_susp_clr)
		else $error("suspend zero did not continue");
	property p_off;
		m_off |=> !o_enabled;
	endproperty
	a_off: assert property (p_off)
		else $error("master off ignored");
	property p_blocked;
		!o_enabled && !i_master.stb |=> $stable(o_cur_step);
	endproperty
	a_blocked: assert property (p_blocked)
		else $error("step ran while switched off");
	property p_on;
		m_on |=> o_enabled && !o_interrupted;
	endproperty
	a_on: assert property (p_on)
		else $error("master on did not re-enable");
	property p_manual;
		i_manual && o_enabled && o_seq_active && !i_master.stb |=> o_interrupted;
	endproperty
	a_manual: assert property (p_manual)
		else $error("manual command did not interrupt");
	property p_time_src;
		$rose(o_time_valid) |-> $past(i_time.stb);
	endproperty
	a_time_src: assert property (p_time_src)
		else $error("time valid without a time telegram");
	property p_time_keep;
		o_time_valid |=> o_time_valid;
	endproperty
	a_time_keep: assert property (p_time_keep)
		else $error("time of day lost");
	property p_scene_src;
		o_scene_stb |-> o_seq_active;
	endproperty
	a_scene_src: assert property (p_scene_src)
		else $error("scene sent outside a sequence");
endmodule
`default_nettype wire

// [tb/dss_bus_model.sv]
/*
 * Bus side model: turns requests into one-cycle telegram strobes.
 * Assumes each send returns before the next one is started.
 */
`timescale 1ns/1ps
`default_nettype none
module dss_bus_model (
	// Clock
	input wire logic i_clk,
	// Telegrams towards the sequencer
	output var dss_pkg::dss_bit_tg_t o_suspend,
	output var dss_pkg::dss_bit_tg_t o_master,
	output var logic [31:0] o_trig_stb,
	output var logic [31:0] o_trig_val,
	output var dss_pkg::dss_byte_tg_t o_scene,
	output var dss_pkg::dss_time_tg_t o_time,
	output var logic o_manual
);
	initial begin
		o_suspend = '0;
		o_master = '0;
		o_trig_stb = '0;
		o_trig_val = '0;
		o_scene = '0;
		o_time = '0;
		o_manual = 1'b0;
	end

	// ==========
	// Kinds: 0 trigger, 1 scene, 2 suspend, 3 master, 4 manual, 5 time
	task automatic send(input int k, input int i, input logic [23:0] v);
		@(posedge i_clk);
		#1;
		case (k)
			0: begin
				o_trig_stb[i] = 1'b1;
				o_trig_val[i] = v[0];
			end
			1: o_scene = '{1'b1, 8'(i)};
			2: o_suspend = '{1'b1, v[0]};
			3: o_master = '{1'b1, v[0]};
			4: o_manual = 1'b1;
			default: o_time = '{1'b1, v};
		endcase
		@(posedge i_clk);
		#1;
		// Released values flip so stale data is never mistaken for fresh
		o_trig_stb = '0;
		o_trig_val = ~o_trig_val;
		o_scene = '{1'b0, ~o_scene.val};
		o_suspend = '{1'b0, ~o_suspend.val};
		o_master = '{1'b0, ~o_master.val};
		o_time = '{1'b0, ~o_time.val};
		o_manual = 1'b0;
	endtask
endmodule
`default_nettype wire

// [tb/dss_sequencer_tb.sv]
/*
 * Self-checking bench of the dimmer step sequencer.
 * Assumes the bus model and the bound port checker beside it.
 */
`timescale 1ns/1ps
`default_nettype none
module dss_sequencer_tb;
	// ==========
	// Signals
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	int fails = 0;
	int check_count = 0;
	dss_pkg::dss_gcfg_t gcfg;
	dss_pkg::dss_step_cfg_t [dss_pkg::NSTEP-1:0] scfg;
	dss_pkg::dss_bit_tg_t susp, mast;
	dss_pkg::dss_byte_tg_t scn;
	dss_pkg::dss_time_tg_t tim;
	logic [31:0] tstb, tval;
	logic man, fading, sc_stb, act, en, sus, intr, tv;
	logic [6:0] level;
	logic [7:0] sc_num;
	logic [4:0] cur;
	// Rows: kind, step or scene, bit, cur step, scene out, level
	logic [7:0] rows [9][6] = '{
		'{8'h00, 8'h01, 8'h01, 8'h01, 8'h11, 8'h00},
		'{8'h00, 8'h00, 8'h01, 8'h00, 8'h11, 8'h00},
		'{8'h00, 8'h04, 8'h01, 8'h04, 8'h14, 8'h00},
		'{8'h01, 8'h12, 8'h00, 8'h02, 8'h12, 8'h00},
		'{8'h00, 8'h06, 8'h01, 8'h02, 8'h12, 8'h00},
		'{8'h00, 8'h03, 8'h01, 8'h03, 8'h12, 8'h32},
		'{8'h00, 8'h05, 8'h01, 8'h01, 8'h11, 8'h32},
		'{8'h00, 8'h05, 8'h00, 8'h01, 8'h11, 8'h32},
		'{8'h00, 8'h05, 8'h01, 8'h05, 8'h11, 8'h32}};

	always #5 clk = ~clk;

	dss_bus_model bus (.i_clk(clk), .o_suspend(susp), .o_master(mast), .o_trig_stb(tstb),
		.o_trig_val(tval), .o_scene(scn), .o_time(tim), .o_manual(man));
	dss_sequencer #(.CS_CYCLES(10)) uut (.i_clk(clk), .i_rst_n(rst_n), .i_gcfg(gcfg),
		.i_step_cfg(scfg), .i_suspend(susp), .i_master(mast), .i_trig_stb(tstb),
		.i_trig_val(tval), .i_scene(scn), .i_time(tim), .i_manual(man), .o_level(level),
		.o_fading(fading), .o_scene_stb(sc_stb), .o_scene_num(sc_num), .o_cur_step(cur),
		.o_seq_active(act), .o_enabled(en), .o_suspended(sus), .o_interrupted(intr),
		.o_time_valid(tv));

	// ==========
	// Tasks
	task automatic chk(input string name, input logic [23:0] seen, input logic [23:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic go(input int k, input int i, input logic [23:0] v);
		bus.send(k, i, v);
		repeat (3) @(posedge clk);
		#1;
	endtask
	task complete_run;
		if (fails == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// ==========
	// Sequence
	initial begin
		gcfg = '{6'h06, dss_pkg::DSS_RES_OBJ, 17'h00000, 5'h04, 1'b1, 1'b1, 5'h01,
			dss_pkg::DSS_OFF_STOP, 5'h00};
		for (int i = 0; i < dss_pkg::NSTEP; i++)
			scfg[i] = '{dss_pkg::DSS_TM_OFF, 17'h00000, 1'b1, 1'b1, 8'h10 + 8'(i),
				dss_pkg::DSS_ACT_SCENE, 7'h00, 17'h00000, 5'h00, 1'b0, 8'h00};
		scfg[0].action = dss_pkg::DSS_ACT_NONE;
		scfg[3].action = dss_pkg::DSS_ACT_BRIGHT;
		scfg[3].level = 7'h32;
		scfg[5].action = dss_pkg::DSS_ACT_LOOP;
		scfg[5].loop_to = 5'h01;
		scfg[5].loop_limited = 1'b1;
		scfg[5].loop_num = 8'h01;
		repeat (20) @(posedge clk);
		#1 rst_n = 1'b1;
		chk("enabled", 24'(en), 24'h1);
		chk("time_valid", 24'(tv), 24'h0);
		chk("level", 24'(level), 24'h0);
		for (int r = 0; r < 9; r++) begin
			go(int'(rows[r][0]), int'(rows[r][1]), 24'(rows[r][2]));
			chk("cur_step", 24'(cur), 24'(rows[r][3]));
			chk("scene_num", 24'(sc_num), 24'(rows[r][4]));
			chk("level", 24'(level), 24'(rows[r][5]));
		end
		go(2, 0, 24'h1);
		chk("suspended", 24'(sus), 24'h1);
		go(0, 4, 24'h1);
		chk("cur_step", 24'(cur), 24'h5);
		go(2, 0, 24'h0);
		chk("suspended", 24'(sus), 24'h0);
		go(4, 0, 24'h0);
		chk("interrupted", 24'(intr), 24'h1);
		go(0, 2, 24'h1);
		chk("cur_step", 24'(cur), 24'h5);
		go(2, 0, 24'h0);
		chk("cur_step", 24'(cur), 24'h4);
		chk("scene_num", 24'(sc_num), 24'h14);
		chk("interrupted", 24'(intr), 24'h0);
		go(3, 0, 24'h0);
		chk("enabled", 24'(en), 24'h0);
		go(0, 1, 24'h1);
		chk("cur_step", 24'(cur), 24'h4);
		go(3, 0, 24'h1);
		chk("cur_step", 24'(cur), 24'h1);
		go(4, 0, 24'h0);
		go(3, 0, 24'h1);
		chk("interrupted", 24'(intr), 24'h0);
		bus.send(0, 2, 24'h1);
		chk("scene_stb", 24'(sc_stb), 24'h1);
		scfg[3].level = 7'h64;
		scfg[3].fade_s = 17'h00001;
		go(0, 3, 24'h1);
		chk("scene_stb", 24'(sc_stb), 24'h0);
		chk("fading", 24'(fading), 24'h1);
		go(3, 0, 24'h0);
		chk("fading", 24'(fading), 24'h0);
		gcfg.off_mode = dss_pkg::DSS_OFF_FINISH;
		go(3, 0, 24'h1);
		go(0, 3, 24'h1);
		go(3, 0, 24'h0);
		chk("fading", 24'(fading), 24'h1);
		repeat (600) @(posedge clk);
		#1;
		chk("level", 24'(level), 24'h64);
		chk("fading", 24'(fading), 24'h0);
		gcfg.off_mode = dss_pkg::DSS_OFF_STEP;
		gcfg.off_step = 5'h02;
		go(3, 0, 24'h1);
		go(3, 0, 24'h0);
		chk("cur_step", 24'(cur), 24'h2);
		gcfg.on_exec = 1'b0;
		go(3, 0, 24'h1);
		chk("cur_step", 24'(cur), 24'h2);
		gcfg.resume_mode = dss_pkg::DSS_RES_OFFT;
		gcfg.off_time_s = 17'h00001;
		go(4, 0, 24'h0);
		repeat (1100) @(posedge clk);
		#1;
		chk("cur_step", 24'(cur), 24'h4);
		chk("interrupted", 24'(intr), 24'h0);
		gcfg.resume_mode = dss_pkg::DSS_RES_NEXT;
		go(4, 0, 24'h0);
		go(0, 2, 24'h1);
		chk("cur_step", 24'(cur), 24'h2);
		chk("interrupted", 24'(intr), 24'h0);
		go(5, 0, 24'h190000);
		chk("time_valid", 24'(tv), 24'h0);
		scfg[4].time_mode = dss_pkg::DSS_TM_TOD;
		scfg[4].start_time = 17'h0AFCE;
		scfg[5].time_mode = dss_pkg::DSS_TM_WAIT;
		scfg[5].start_time = 17'h00001;
		go(5, 0, 24'h0C1E05);
		chk("time_valid", 24'(tv), 24'h1);
		repeat (1100) @(posedge clk);
		#1;
		chk("cur_step", 24'(cur), 24'h4);
		repeat (1000) @(posedge clk);
		#1;
		chk("cur_step", 24'(cur), 24'h1);
		complete_run();
	end

	// Generous bound; the sequence needs about four thousand cycles
	initial begin
		#200_000;
		fails++;
		complete_run();
	end
endmodule

bind dss_sequencer dss_sequencer_properties u_props (.i_clk, .i_rst_n, .i_gcfg, .i_suspend,
	.i_master, .i_time, .i_manual, .o_level, .o_scene_stb, .o_cur_step, .o_seq_active,
	.o_enabled, .o_suspended, .o_interrupted, .o_time_valid);
`default_nettype wire
